// [logic/dsp_pwm_timer.sv]
// Dual-slope symmetric PWM timer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_timer
  import dsp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [DSP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [DSP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       compare_output_a,
  output logic                       compare_output_b,
  output logic                       pin_drive_a,
  output logic                       pin_drive_b
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  // The count must fit one bus word and be wide enough for the least top.
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("dsp_pwm_timer: CNT_W must lie between 2 and 16");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_BOT = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  dsp_ctrl_a_t       ctrl_a;
  dsp_ctrl_b_t       ctrl_b;
  dsp_flags_t        flags;
  logic [1:0]        pin_dir;
  logic [CNT_W-1:0]  count_value;
  logic              count_up;
  logic [CNT_W-1:0]  capture_top_register;
  logic [CNT_W-1:0]  cmp_buf [2];
  logic [CNT_W-1:0]  cmp_act [2];
  logic [1:0]        cmp_out;
  logic [1:0]        force_pulse;
  logic [9:0]        presc_cnt;
  logic [9:0]        presc_lim;
  logic              presc_run;
  logic              timer_tick;
  logic [3:0]        waveform_mode_sel;
  logic              pwm_mode;
  logic              plain_mode;
  logic              ctc_mode;
  logic [CNT_W-1:0]  top_value;
  logic              at_top;
  logic              at_bottom;
  logic              eff_up;
  logic [1:0]        match;
  logic              aw_full;
  logic              w_full;
  logic [DSP_ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              wr_mapped;
  logic [2:0]        wr_idx;
  logic [31:0]       rd_word;

  // Byte-lane merge of a write into a zero-extended register value.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ==========================================================================
  // Mode decode and top selection
  // ==========================================================================
  // Upper mode bits live in control B, the lower two in control A.
  assign waveform_mode_sel = {ctrl_b.wave_high, ctrl_a.wave_low};
  assign pwm_mode   = (waveform_mode_sel == DSP_MODE_PFC_CAP) ||
                      (waveform_mode_sel == DSP_MODE_PFC_CMPA);
  assign ctc_mode   = (waveform_mode_sel == DSP_MODE_CTC_CMPA) ||
                      (waveform_mode_sel == DSP_MODE_CTC_CAP);
  assign plain_mode = ctc_mode || (waveform_mode_sel == DSP_MODE_NORMAL);

  // Top comes from the capture register or the live compare A value, else CNT_MAX.
  always_comb begin
    unique case (waveform_mode_sel)
      DSP_MODE_PFC_CAP, DSP_MODE_CTC_CAP:  top_value = capture_top_register;
      DSP_MODE_PFC_CMPA, DSP_MODE_CTC_CMPA: top_value = cmp_act[0];
      default:                             top_value = CNT_MAX;
    endcase
  end

  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == CNT_BOT);
  // A match at bottom counts as rising and one at top as falling, so in non-inverting
  // mode a compare of zero stays low and a compare equal to top stays high.
  assign eff_up    = at_bottom ? 1'b1 : (at_top ? 1'b0 : count_up);

  // ==========================================================================
  // Prescaler
  // ==========================================================================
  // Terminal count of the divider for the selected prescale factor.
  always_comb begin
    presc_run = 1'b1;
    unique case (ctrl_b.presc_sel)
      DSP_PRE_1:    presc_lim = DSP_LIM_1;
      DSP_PRE_8:    presc_lim = DSP_LIM_8;
      DSP_PRE_64:   presc_lim = DSP_LIM_64;
      DSP_PRE_256:  presc_lim = DSP_LIM_256;
      DSP_PRE_1024: presc_lim = DSP_LIM_1024;
      default: begin
        presc_lim = DSP_LIM_1;
        presc_run = 1'b0;
      end
    endcase
  end

  // The tick is a one-cycle enable on aclk, never a clock of its own.
  always_ff @(posedge aclk) begin
    if (!aresetn || !presc_run || presc_cnt >= presc_lim) begin
      presc_cnt <= 10'h000;
    end else begin
      presc_cnt <= presc_cnt + 10'h001;
    end
  end
  assign timer_tick = presc_run && (presc_cnt >= presc_lim);

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A bus write to the count wins over the tick in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= CNT_BOT;
      count_up    <= 1'b1;
    end else if (wr_fire && wr_idx == DSP_OFF_COUNT[4:2]) begin
      count_value <= CNT_W'(lane_merge(32'(count_value), w_data, w_strb));
    end else if (timer_tick && pwm_mode) begin
      if (count_up) begin
        if (at_top && !at_bottom) begin
          count_value <= count_value - CNT_ONE;
          count_up    <= 1'b0;
        end else if (!at_top) begin
          count_value <= count_value + CNT_ONE;
        end
      end else if (at_bottom) begin
        count_value <= CNT_ONE;
        count_up    <= 1'b1;
      end else begin
        count_value <= count_value - CNT_ONE;
      end
    end else if (timer_tick && plain_mode) begin
      count_up    <= 1'b1;
      count_value <= (ctc_mode && at_top) ? CNT_BOT : count_value + CNT_ONE;
    end
  end

  // ==========================================================================
  // Compare channels
  // ==========================================================================
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [1:0]  com;
    logic [31:0] my_off;
    assign com    = (ch == 0) ? ctrl_a.com_a : ctrl_a.com_b;
    assign my_off = (ch == 0) ? 32'(DSP_OFF_CMP_A) : 32'(DSP_OFF_CMP_B);
    assign match[ch] = (count_value == cmp_act[ch]);

    // Buffered compare value, written by software.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_buf[ch] <= CNT_BOT;
      end else if (wr_fire && wr_idx == my_off[4:2]) begin
        cmp_buf[ch] <= CNT_W'(lane_merge(32'(cmp_buf[ch]), w_data,
                                         w_strb));
      end
    end

    // The live value reloads only at bottom in PWM, so both slopes of a
    // period share one compare and the pulse stays symmetric.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_act[ch] <= CNT_BOT;
      end else if (!pwm_mode || (timer_tick && at_bottom)) begin
        cmp_act[ch] <= cmp_buf[ch];
      end
    end

    // Waveform level of the channel.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_out[ch] <= 1'b0;
      end else if (pwm_mode) begin
        if (timer_tick && match[ch]) begin
          if (com == DSP_COM_NONINV || com == DSP_COM_INV) begin
            cmp_out[ch] <= ~eff_up ^ com[0];
          end else if (ch == 0 && com == DSP_COM_TOGGLE &&
                       waveform_mode_sel == DSP_MODE_PFC_CMPA) begin
            cmp_out[ch] <= ~cmp_out[ch];
          end
        end
      end else if (plain_mode && ((timer_tick && match[ch]) ||
                                  force_pulse[ch])) begin
        unique case (com)
          DSP_COM_TOGGLE: cmp_out[ch] <= ~cmp_out[ch];
          DSP_COM_NONINV: cmp_out[ch] <= 1'b0;
          DSP_COM_INV:    cmp_out[ch] <= 1'b1;
          DSP_COM_OFF:    cmp_out[ch] <= cmp_out[ch];
        endcase
      end
    end
  end

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  // Registered so that every pin output comes straight from a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      pin_drive_a      <= 1'b0;
      pin_drive_b      <= 1'b0;
    end else begin
      compare_output_a <= cmp_out[0];
      compare_output_b <= cmp_out[1];
      pin_drive_a      <= (ctrl_a.com_a != DSP_COM_OFF) && pin_dir[0];
      pin_drive_b      <= (ctrl_a.com_b != DSP_COM_OFF) && pin_dir[1];
    end
  end

  // ==========================================================================
  // Control, capture and direction registers
  // ==========================================================================
  // Force bits are strobes: they never store and last one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a      <= DSP_CTRL_A_RST;
      force_pulse <= 2'b00;
    end else if (wr_fire && wr_idx == DSP_OFF_CTRL_A[4:2] && w_strb[0]) begin
      ctrl_a      <= dsp_ctrl_a_t'({w_data[7:4], 2'b00, w_data[1:0]});
      force_pulse <= {w_data[2], w_data[3]};
    end else begin
      force_pulse <= 2'b00;
    end
  end

  // Control B, capture top and pin direction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_b               <= DSP_CTRL_B_RST;
      capture_top_register <= CNT_BOT;
      pin_dir              <= 2'b00;
    end else if (wr_fire) begin
      if (wr_idx == DSP_OFF_CTRL_B[4:2] && w_strb[0]) begin
        ctrl_b <= dsp_ctrl_b_t'(w_data[4:0]);
      end
      if (wr_idx == DSP_OFF_CAPTURE[4:2]) begin
        capture_top_register <= CNT_W'(lane_merge(32'(capture_top_register),
                                                  w_data, w_strb));
      end
      if (wr_idx == DSP_OFF_PIN_DIR[4:2] && w_strb[0]) begin
        pin_dir <= w_data[1:0];
      end
    end
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  // Write one to clear; a flag set in the clearing cycle survives.
  always_ff @(posedge aclk) begin
    dsp_flags_t set_v;
    dsp_flags_t clr_v;
    set_v = '0;
    clr_v = '0;
    if (!aresetn) begin
      flags <= DSP_FLAGS_RST;
    end else begin
      if (wr_fire && wr_idx == DSP_OFF_FLAGS[4:2] && w_strb[0]) begin
        clr_v = dsp_flags_t'(w_data[3:0]);
      end
      if (timer_tick && (pwm_mode || plain_mode)) begin
        set_v.overflow = pwm_mode ? at_bottom
                                  : (count_value == CNT_MAX);
        set_v.match_a  = match[0];
        set_v.match_b  = match[1];
        set_v.capture  = at_top && (waveform_mode_sel == DSP_MODE_PFC_CAP ||
                         waveform_mode_sel == DSP_MODE_CTC_CAP);
      end
      flags <= (flags & ~clr_v) | set_v;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  // Only mapped writes reach the registers; refused ones are still answered.
  assign wr_fire   = aw_full && w_full && !s_axi_bvalid && wr_mapped;
  assign wr_idx    = aw_addr[4:2];
  assign wr_mapped = (aw_addr[7:5] == DSP_MAP_HIGH);

  // Address and data are held independently until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_full) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_full) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? DSP_RESP_OKAY : DSP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  // Force strobes always read back as zero.
  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr[4:2])
      DSP_OFF_CTRL_A[4:2]:  rd_word[7:0] = {ctrl_a.com_a, ctrl_a.com_b,
                                            2'b00, ctrl_a.wave_low};
      DSP_OFF_CTRL_B[4:2]:  rd_word[4:0] = ctrl_b;
      DSP_OFF_COUNT[4:2]:   rd_word = 32'(count_value);
      DSP_OFF_CMP_A[4:2]:   rd_word = 32'(cmp_buf[0]);
      DSP_OFF_CMP_B[4:2]:   rd_word = 32'(cmp_buf[1]);
      DSP_OFF_CAPTURE[4:2]: rd_word = 32'(capture_top_register);
      DSP_OFF_FLAGS[4:2]:   rd_word[3:0] = flags;
      DSP_OFF_PIN_DIR[4:2]: rd_word[1:0] = pin_dir;
    endcase
  end

  // One read at a time; the answer follows the address by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= DSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (s_axi_araddr[7:5] == DSP_MAP_HIGH) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= DSP_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= DSP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : dsp_pwm_timer

`default_nettype wire

// [inc/dsp_pkg.sv]
// Constants, register map and packed carriers of the dual-slope PWM timer.
package dsp_pkg;

  // ==========================================================================
  // Bus and register map
  // ==========================================================================
  localparam int          DSP_ADDR_W        = 8;
  localparam logic [7:0]  DSP_OFF_CTRL_A    = 8'h00;
  localparam logic [7:0]  DSP_OFF_CTRL_B    = 8'h04;
  localparam logic [7:0]  DSP_OFF_COUNT     = 8'h08;
  localparam logic [7:0]  DSP_OFF_CMP_A     = 8'h0C;
  localparam logic [7:0]  DSP_OFF_CMP_B     = 8'h10;
  localparam logic [7:0]  DSP_OFF_CAPTURE   = 8'h14;
  localparam logic [7:0]  DSP_OFF_FLAGS     = 8'h18;
  localparam logic [7:0]  DSP_OFF_PIN_DIR   = 8'h1C;
  localparam logic [2:0]  DSP_MAP_HIGH      = 3'h0;
  localparam logic [1:0]  DSP_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  DSP_RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [1:0]  DSP_COM_OFF       = 2'h0;
  localparam logic [1:0]  DSP_COM_TOGGLE    = 2'h1;
  localparam logic [1:0]  DSP_COM_NONINV    = 2'h2;
  localparam logic [1:0]  DSP_COM_INV       = 2'h3;
  localparam logic [3:0]  DSP_MODE_NORMAL   = 4'h0;
  localparam logic [3:0]  DSP_MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0]  DSP_MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0]  DSP_MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0]  DSP_MODE_CTC_CAP  = 4'hC;

  // Prescale selector codes and their terminal counts (divide minus one).
  localparam logic [2:0]  DSP_PRE_STOP      = 3'h0;
  localparam logic [2:0]  DSP_PRE_1         = 3'h1;
  localparam logic [2:0]  DSP_PRE_8         = 3'h2;
  localparam logic [2:0]  DSP_PRE_64        = 3'h3;
  localparam logic [2:0]  DSP_PRE_256       = 3'h4;
  localparam logic [2:0]  DSP_PRE_1024      = 3'h5;
  localparam logic [9:0]  DSP_LIM_1         = 10'h000;
  localparam logic [9:0]  DSP_LIM_8         = 10'h007;
  localparam logic [9:0]  DSP_LIM_64        = 10'h03F;
  localparam logic [9:0]  DSP_LIM_256       = 10'h0FF;
  localparam logic [9:0]  DSP_LIM_1024      = 10'h3FF;

  // ==========================================================================
  // Packed register layouts
  // ==========================================================================
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic       force_a;
    logic       force_b;
    logic [1:0] wave_low;
  } dsp_ctrl_a_t;

  typedef struct packed {
    logic [2:0] presc_sel;
    logic [1:0] wave_high;
  } dsp_ctrl_b_t;

  typedef struct packed {
    logic capture;
    logic match_b;
    logic match_a;
    logic overflow;
  } dsp_flags_t;

  localparam dsp_ctrl_a_t DSP_CTRL_A_RST    = 8'h00;
  localparam dsp_ctrl_b_t DSP_CTRL_B_RST    = 5'h00;
  localparam dsp_flags_t  DSP_FLAGS_RST     = 4'h0;

endpackage : dsp_pkg

// [bench/dsp_pwm_assertions.sv]
// Port-level checker of the dual-slope PWM timer, bound onto its top module.
`timescale 1ns/1ps
`default_nettype none
module dsp_pwm_assertions
  import dsp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_output_b,
  input wire logic        pin_drive_b
);
  // ==========================================================================
  // Bus and pin relations
  // ==========================================================================
  // One clock domain, so clock and reset are given once for every check.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_quiet: assert property ($rose(aresetn) |->
    !compare_output_b && !pin_drive_b && !s_axi_awready)
    else $error("outputs not quiet after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer repeated");
  a_write_drop: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answer repeated");
  a_err_data: assert property (s_axi_rvalid &&
    s_axi_rresp == DSP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready [*2]) else $error("write address taken twice");
  // A pin only changes hands after a register write has been answered.
  a_drive_cause: assert property ($changed(pin_drive_b) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pin drive changed without a write");

  c_refused: cover property (s_axi_rvalid && s_axi_rresp == DSP_RESP_SLVERR);
  c_wave: cover property ($rose(compare_output_b));
  c_drive: cover property ($rose(pin_drive_b));
endmodule : dsp_pwm_assertions

bind dsp_pwm_timer dsp_pwm_assertions #(.CNT_W(CNT_W)) u_chk (.aclk,
  .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .compare_output_b, .pin_drive_b);
`default_nettype wire

// [bench/dsp_pin_load.sv]
// Load on one compare output pin, with a pull-up on the line.
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_load (
  input  wire logic  aclk,
  input  wire logic  level,
  input  wire logic  drive,
  output var logic [15:0] n_high = 16'h0
);
  // ==========================================================================
  // Pin level
  // ==========================================================================
  // An undriven pin floats up, so a missing drive shows as high time.
  wire logic pin = drive ? level : 1'b1;
  // Free-running high count; the bench takes differences, so no clear.
  always @(posedge aclk) begin
    n_high <= n_high + 16'(pin);
  end
endmodule : dsp_pin_load
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the dual-slope PWM timer over its register bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import dsp_pkg::*;
  typedef struct packed {
    logic [7:0]  cb, ca, cmpb;
    logic [3:0]  fl;
    logic [15:0] win, hib, hia;
  } dsp_case_t;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pin_drive_a, pin_drive_b;
  logic        compare_output_a, compare_output_b;
  logic [15:0] hi_a, hi_b, a0, b0;
  int          n_errors = 0;
  int          n_checks = 0;
  dsp_case_t   cases [6];

  dsp_pwm_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compare_output_a, .compare_output_b, .pin_drive_a, .pin_drive_b);
  dsp_pin_load u_load_a (.aclk, .level(compare_output_a),
    .drive(pin_drive_a), .n_high(hi_a));
  dsp_pin_load u_load_b (.aclk, .level(compare_output_b),
    .drive(pin_drive_b), .n_high(hi_b));

  // ==========================================================================
  // Bus tasks and verdict
  // ==========================================================================
  // Write one word; every request is held until its own ready edge.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  // Read one word, returning its data and response code.
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Free-running 200 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // The whole run needs a few thousand cycles, so this limit is generous.
  initial begin
    #(20000 * 5);
    n_errors++;
    test_done();
  end
  // Main sequence: reset, register behaviour, then the waveform table.
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, aresetn} = '0;
    s_axi_wstrb = 4'hF;
    // Mode 9/8 at top 8; windows are two periods, so edges never matter.
    cases[0] = '{8'h06, 8'h61, 8'h03, 4'h7, 16'h20, 16'h0C, 16'h10};
    cases[1] = '{8'h06, 8'h71, 8'h03, 4'h7, 16'h20, 16'h14, 16'h10};
    cases[2] = '{8'h06, 8'h61, 8'h00, 4'h7, 16'h20, 16'h00, 16'h10};
    cases[3] = '{8'h06, 8'h61, 8'h08, 4'h7, 16'h20, 16'h20, 16'h10};
    cases[4] = '{8'h06, 8'hA0, 8'h03, 4'hF, 16'h20, 16'h0C, 16'h20};
    cases[5] = '{8'h0A, 8'hA0, 8'h03, 4'hF, 16'h100, 16'h60, 16'h100};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pin_drive_b", 1'b0, pin_drive_b)
    `CHK("compare_output_b", 1'b0, compare_output_b)
    axr(DSP_OFF_CTRL_A, rd, rr);
    `CHK("ctrl_a reset", 32'h0, rd)
    axr(DSP_OFF_FLAGS, rd, rr);
    `CHK("flags reset", 32'h0, rd)
    $display("test reset done");
    axw(DSP_OFF_CTRL_A, 32'hFD);
    axr(DSP_OFF_CTRL_A, rd, rr);
    `CHK("ctrl_a force", 32'hF1, rd)
    axr(8'hE0, rd, rr);
    `CHK("unmapped resp", DSP_RESP_SLVERR, rr)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    axw(DSP_OFF_CMP_A, 32'h8);
    axw(DSP_OFF_CAPTURE, 32'h8);
    axw(DSP_OFF_PIN_DIR, 32'h3);
    foreach (cases[i]) begin
      axw(DSP_OFF_CTRL_B, 32'(cases[i].cb));
      axw(DSP_OFF_CTRL_A, 32'(cases[i].ca));
      axw(DSP_OFF_CMP_B, 32'(cases[i].cmpb));
      repeat (3 * cases[i].win) @(posedge aclk);
      axw(DSP_OFF_FLAGS, 32'hF);
      repeat (cases[i].win) @(posedge aclk);
      a0 = hi_a;
      b0 = hi_b;
      repeat (cases[i].win) @(posedge aclk);
      `CHK("pin_drive_b", 1'b1, pin_drive_b)
      `CHK("high time b", cases[i].hib, 16'(hi_b - b0))
      `CHK("high time a", cases[i].hia, 16'(hi_a - a0))
      axr(DSP_OFF_FLAGS, rd, rr);
      `CHK("flags", cases[i].fl, rd[3:0])
      $display("test waveform %0d done", i);
    end
    axw(DSP_OFF_PIN_DIR, 32'h0);
    repeat (4) @(posedge aclk);
    `CHK("pin_drive_b off", 1'b0, pin_drive_b)
    `CHK("pin_drive_a off", 1'b0, pin_drive_a)
    $display("test direction done");
    // Normal mode with the prescaler stopped: only force strobes act.
    axw(DSP_OFF_CTRL_B, 32'h0);
    axw(DSP_OFF_CTRL_A, 32'h34);
    repeat (2) @(posedge aclk);
    `CHK("forced set b", 1'b1, compare_output_b)
    axw(DSP_OFF_CTRL_A, 32'h24);
    repeat (2) @(posedge aclk);
    `CHK("forced clear b", 1'b0, compare_output_b)
    axw(DSP_OFF_CTRL_A, 32'h14);
    repeat (2) @(posedge aclk);
    `CHK("forced toggle b", 1'b1, compare_output_b)
    $display("test force done");
    test_done();
  end
endmodule : tb
`default_nettype wire
